/* File: core/edge_flag_bank.sv */
// One bank of rising-edge event flags with clear-on-read and write-one-to-clear.
`timescale 1ns/1ps
`default_nettype none
module edge_flag_bank
  import event_status_pkg::*;
#(
  parameter word_t VALID = 16'hffff
) (
  input  wire logic  core_clk,
  input  wire logic  arst_n,
  input  wire word_t source,
  input  wire logic  read_clear,
  input  wire word_t write_clear,
  output var  word_t flags,
  output var  word_t rise
);

  typedef struct packed {
    word_t prev;
    word_t flags;
  } bank_state_t;

  bank_state_t state_r;
  bank_state_t state_nxt;
  word_t       clear_vec;

  always_comb begin
    // [R1] edge not level
    rise      = source & ~state_r.prev & VALID;
    clear_vec = write_clear | {DATA_W{read_clear}};
    state_nxt.prev = source;
    // [R2] set beats clear
    // [R13] unassigned bits stay zero
    state_nxt.flags = ((state_r.flags & ~clear_vec) | rise) & VALID;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign flags = state_r.flags;

endmodule
`default_nettype wire

/* File: core/event_status_pkg.sv */
// Constants and types shared by the second-level event status block.
// Function
// [R1] Every flag is set by a low-to-high change of its source, never again by a held level.
// [R2] Reading a status register returns its flags and clears them, while a new edge in that cycle still sets.
// [R3] First register bit 15 holds battery over-temperature and bit 14 battery under-temperature.
// [R4] First register bits 13 to 9 hold battery fault, charge timeout, final stage, charge begun, fast ready.
// [R5] First register bits 7, 6 and 5 hold the clock periodic tick, one-second rollover and alarm.
// [R6] First register bits 2, 1 and 0 hold battery below 3.9 V, 3.1 V and 2.85 V.
// [R7] Second register bit 13 holds loss of current sink drain regulation.
// [R8] Second register bit 10 holds the bus current limit switch event.
// [R9] Second register bit 8 holds converter data ready and bits 7 to 4 comparators four to one.
// [R10] Second register bit 3 holds the supply falling below the shutdown threshold.
// [R11] Second register bit 2 holds die above 115 C and bit 1 die above 140 C.
// [R12] Second register bit 0 holds the watchdog timeout.
// [R13] All flags are zero after reset and unassigned bits read zero and ignore writes.
package event_status_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 16;

  // ==========================================================================
  // Register map
  localparam logic [ADDR_W-1:0] CHARGER_RTC_EVENT_STATUS_ADDR = 8'h19;
  localparam logic [ADDR_W-1:0] SYSTEM_AUX_EVENT_STATUS_ADDR  = 8'h1a;
  localparam logic [ADDR_W-1:0] CHARGER_RTC_EVENT_MASK_ADDR   = 8'h40;
  localparam logic [ADDR_W-1:0] SYSTEM_AUX_EVENT_MASK_ADDR    = 8'h41;

  localparam logic [DATA_W-1:0] STATUS_RESET = 16'h0000;
  localparam logic [DATA_W-1:0] MASK_RESET   = 16'h0000;
  localparam logic [DATA_W-1:0] READ_IDLE    = 16'h0000;

  // Assigned bits of each status register.
  localparam logic [DATA_W-1:0] CHARGER_RTC_VALID = 16'hfee7;
  localparam logic [DATA_W-1:0] SYSTEM_AUX_VALID  = 16'h25ff;

  // ==========================================================================
  // Charger and clock register fields
  localparam int unsigned BATTERY_OVER_TEMP_BIT  = 15;
  localparam int unsigned BATTERY_UNDER_TEMP_BIT = 14;
  localparam int unsigned BATTERY_FAULT_BIT      = 13;
  localparam int unsigned CHARGE_TIMEOUT_BIT     = 12;
  localparam int unsigned CHARGE_FINAL_STAGE_BIT = 11;
  localparam int unsigned CHARGE_BEGUN_BIT       = 10;
  localparam int unsigned FAST_CHARGE_READY_BIT  = 9;
  localparam int unsigned CLOCK_PERIODIC_BIT     = 7;
  localparam int unsigned CLOCK_SECOND_BIT       = 6;
  localparam int unsigned CLOCK_ALARM_BIT        = 5;
  localparam int unsigned BATT_BELOW_HIGH_BIT    = 2;
  localparam int unsigned BATT_BELOW_MID_BIT     = 1;
  localparam int unsigned BATT_BELOW_LOW_BIT     = 0;

  // ==========================================================================
  // System and auxiliary register fields
  localparam int unsigned SINK_REGULATION_LOST_BIT  = 13;
  localparam int unsigned BUS_CURRENT_LIMIT_BIT     = 10;
  localparam int unsigned AUX_CONV_DONE_BIT         = 8;
  localparam int unsigned AUX_COMPARE_FOUR_BIT      = 7;
  localparam int unsigned AUX_COMPARE_THREE_BIT     = 6;
  localparam int unsigned AUX_COMPARE_TWO_BIT       = 5;
  localparam int unsigned AUX_COMPARE_ONE_BIT       = 4;
  localparam int unsigned SUPPLY_SHUTDOWN_LEVEL_BIT = 3;
  localparam int unsigned DIE_WARM_BIT              = 2;
  localparam int unsigned DIE_HOT_BIT               = 1;
  localparam int unsigned WATCHDOG_EXPIRED_BIT      = 0;

  typedef logic [DATA_W-1:0] word_t;

endpackage

/* File: core/event_status_top.sv */
// Second-level event status registers with register port and interrupt output.
//
// The implementer's own choice: the plain strobed port.
`timescale 1ns/1ps
`default_nettype none
module event_status_top (
  input  wire logic                               core_clk,
  input  wire logic                               arst_n,
  input  wire logic [event_status_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [event_status_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                               reg_wr,
  input  wire logic                               reg_rd,
  output var  logic [event_status_pkg::DATA_W-1:0] reg_rdata,
  output var  logic                               irq_out,
  input  wire logic                               battery_over_temp_src,
  input  wire logic                               battery_under_temp_src,
  input  wire logic                               battery_fault_src,
  input  wire logic                               charge_timeout_src,
  input  wire logic                               charge_final_stage_src,
  input  wire logic                               charge_begun_src,
  input  wire logic                               fast_charge_ready_src,
  input  wire logic                               clock_periodic_src,
  input  wire logic                               clock_second_src,
  input  wire logic                               clock_alarm_src,
  input  wire logic                               batt_below_high_src,
  input  wire logic                               batt_below_mid_src,
  input  wire logic                               batt_below_low_src,
  input  wire logic                               sink_regulation_lost_src,
  input  wire logic                               bus_current_limit_src,
  input  wire logic                               aux_conv_done_src,
  input  wire logic                               aux_compare_four_src,
  input  wire logic                               aux_compare_three_src,
  input  wire logic                               aux_compare_two_src,
  input  wire logic                               aux_compare_one_src,
  input  wire logic                               supply_shutdown_level_src,
  input  wire logic                               die_warm_src,
  input  wire logic                               die_hot_src,
  input  wire logic                               watchdog_expired_src
);
  import event_status_pkg::*;

  // ==========================================================================
  // State
  typedef struct packed {
    word_t rdata;
    logic  irq;
    word_t charger_rtc_mask;
    word_t system_aux_mask;
  } top_state_t;

  top_state_t state_r;
  top_state_t state_nxt;

  word_t charger_rtc_raw;
  word_t system_aux_raw;
  word_t charger_rtc_sync;
  word_t system_aux_sync;
  word_t charger_rtc_flag;
  word_t system_aux_flag;
  word_t charger_rtc_rise;
  word_t system_aux_rise;
  word_t charger_rtc_w1c;
  word_t system_aux_w1c;
  logic  charger_rtc_rd;
  logic  system_aux_rd;

  // ==========================================================================
  // Source assembly
  always_comb begin
    charger_rtc_raw = '0;
    // [R3] battery temperature events
    charger_rtc_raw[BATTERY_OVER_TEMP_BIT]  = battery_over_temp_src;
    charger_rtc_raw[BATTERY_UNDER_TEMP_BIT] = battery_under_temp_src;
    // [R4] charger events
    charger_rtc_raw[BATTERY_FAULT_BIT]      = battery_fault_src;
    charger_rtc_raw[CHARGE_TIMEOUT_BIT]     = charge_timeout_src;
    charger_rtc_raw[CHARGE_FINAL_STAGE_BIT] = charge_final_stage_src;
    charger_rtc_raw[CHARGE_BEGUN_BIT]       = charge_begun_src;
    charger_rtc_raw[FAST_CHARGE_READY_BIT]  = fast_charge_ready_src;
    // [R5] clock events
    charger_rtc_raw[CLOCK_PERIODIC_BIT]     = clock_periodic_src;
    charger_rtc_raw[CLOCK_SECOND_BIT]       = clock_second_src;
    charger_rtc_raw[CLOCK_ALARM_BIT]        = clock_alarm_src;
    // [R6] battery voltage monitors
    charger_rtc_raw[BATT_BELOW_HIGH_BIT]    = batt_below_high_src;
    charger_rtc_raw[BATT_BELOW_MID_BIT]     = batt_below_mid_src;
    charger_rtc_raw[BATT_BELOW_LOW_BIT]     = batt_below_low_src;
  end

  always_comb begin
    system_aux_raw = '0;
    // [R7] current sink regulation
    system_aux_raw[SINK_REGULATION_LOST_BIT]  = sink_regulation_lost_src;
    // [R8] current limit switch
    system_aux_raw[BUS_CURRENT_LIMIT_BIT]     = bus_current_limit_src;
    // [R9] converter and comparators
    system_aux_raw[AUX_CONV_DONE_BIT]         = aux_conv_done_src;
    system_aux_raw[AUX_COMPARE_FOUR_BIT]      = aux_compare_four_src;
    system_aux_raw[AUX_COMPARE_THREE_BIT]     = aux_compare_three_src;
    system_aux_raw[AUX_COMPARE_TWO_BIT]       = aux_compare_two_src;
    system_aux_raw[AUX_COMPARE_ONE_BIT]       = aux_compare_one_src;
    // [R10] supply hysteresis comparator
    system_aux_raw[SUPPLY_SHUTDOWN_LEVEL_BIT] = supply_shutdown_level_src;
    // [R11] die temperature monitors
    system_aux_raw[DIE_WARM_BIT]              = die_warm_src;
    system_aux_raw[DIE_HOT_BIT]               = die_hot_src;
    // [R12] watchdog timeout
    system_aux_raw[WATCHDOG_EXPIRED_BIT]      = watchdog_expired_src;
  end

  // ==========================================================================
  // Synchronisers and flag banks
  // The sources come from analogue and slow-clock logic, so every one is
  // resynchronised; an edge shorter than a clock period may be missed.
  level_sync #(
    .WIDTH (DATA_W)
  ) u_charger_rtc_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in (charger_rtc_raw),
    .sync_out (charger_rtc_sync)
  );

  level_sync #(
    .WIDTH (DATA_W)
  ) u_system_aux_sync (
    .core_clk (core_clk),
    .arst_n   (arst_n),
    .async_in (system_aux_raw),
    .sync_out (system_aux_sync)
  );

  edge_flag_bank #(
    .VALID (CHARGER_RTC_VALID)
  ) u_charger_rtc_bank (
    .core_clk    (core_clk),
    .arst_n      (arst_n),
    .source      (charger_rtc_sync),
    .read_clear  (charger_rtc_rd),
    .write_clear (charger_rtc_w1c),
    .flags       (charger_rtc_flag),
    .rise        (charger_rtc_rise)
  );

  edge_flag_bank #(
    .VALID (SYSTEM_AUX_VALID)
  ) u_system_aux_bank (
    .core_clk    (core_clk),
    .arst_n      (arst_n),
    .source      (system_aux_sync),
    .read_clear  (system_aux_rd),
    .write_clear (system_aux_w1c),
    .flags       (system_aux_flag),
    .rise        (system_aux_rise)
  );

  // ==========================================================================
  // Register port
  always_comb begin
    // [R2] read clears the addressed bank
    charger_rtc_rd  = reg_rd && (reg_addr == CHARGER_RTC_EVENT_STATUS_ADDR);
    system_aux_rd   = reg_rd && (reg_addr == SYSTEM_AUX_EVENT_STATUS_ADDR);
    // Writing ones also clears, for software that prefers not to read.
    charger_rtc_w1c = '0;
    system_aux_w1c  = '0;
    if (reg_wr && (reg_addr == CHARGER_RTC_EVENT_STATUS_ADDR)) begin
      charger_rtc_w1c = reg_wdata;
    end
    if (reg_wr && (reg_addr == SYSTEM_AUX_EVENT_STATUS_ADDR)) begin
      system_aux_w1c = reg_wdata;
    end
  end

  always_comb begin
    state_nxt       = state_r;
    state_nxt.rdata = READ_IDLE;
    if (reg_wr) begin
      case (reg_addr)
        CHARGER_RTC_EVENT_MASK_ADDR: begin
          state_nxt.charger_rtc_mask = reg_wdata & CHARGER_RTC_VALID;
        end
        SYSTEM_AUX_EVENT_MASK_ADDR: begin
          state_nxt.system_aux_mask = reg_wdata & SYSTEM_AUX_VALID;
        end
        default: begin
        end
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        CHARGER_RTC_EVENT_STATUS_ADDR: begin
          state_nxt.rdata = charger_rtc_flag;
        end
        SYSTEM_AUX_EVENT_STATUS_ADDR: begin
          state_nxt.rdata = system_aux_flag;
        end
        CHARGER_RTC_EVENT_MASK_ADDR: begin
          state_nxt.rdata = state_r.charger_rtc_mask;
        end
        SYSTEM_AUX_EVENT_MASK_ADDR: begin
          state_nxt.rdata = state_r.system_aux_mask;
        end
        default: begin
          state_nxt.rdata = READ_IDLE;
        end
      endcase
    end
    // The request lags the flags by one cycle, keeping the output registered.
    state_nxt.irq = |(charger_rtc_flag & ~state_r.charger_rtc_mask)
                  | |(system_aux_flag & ~state_r.system_aux_mask);
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r.rdata            <= READ_IDLE;
      state_r.irq              <= 1'b0;
      state_r.charger_rtc_mask <= MASK_RESET;
      state_r.system_aux_mask  <= MASK_RESET;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign reg_rdata = state_r.rdata;
  assign irq_out   = state_r.irq;

  // ==========================================================================
  // Assertions
  // [R1] edge sets flag
  rise_sets_charger_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    charger_rtc_rise != '0 |=> (charger_rtc_flag & $past(charger_rtc_rise)) == $past(charger_rtc_rise))
    else $error("charger clock flag missed a rising edge");

  // [R1] held level does not re-set
  no_level_set_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    1'b1 |=> (system_aux_flag & ~$past(system_aux_flag) & ~$past(system_aux_rise)) == '0)
    else $error("system flag set without a rising edge");

  // [R1] held source sets once
  held_source_once_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(charger_rtc_sync[CLOCK_ALARM_BIT]) ##1 charger_rtc_rd ##1
      charger_rtc_sync[CLOCK_ALARM_BIT] |-> !charger_rtc_flag[CLOCK_ALARM_BIT])
    else $error("held alarm source set its flag again");

  // [R2] read returns flags
  read_returns_flags_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    charger_rtc_rd |=> reg_rdata == $past(charger_rtc_flag))
    else $error("status read did not return latched flags");

  // [R2] read clears but keeps new edge
  read_clears_flags_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    system_aux_rd |=> system_aux_flag == $past(system_aux_rise))
    else $error("status read did not clear or lost a new edge");

  // [R2] read data only after read
  rdata_idle_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    !reg_rd |=> reg_rdata == READ_IDLE)
    else $error("read data present without a read");

  // [R3] over temperature lands on its bit
  batt_hot_bit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(charger_rtc_sync[BATTERY_OVER_TEMP_BIT]) |=> charger_rtc_flag[BATTERY_OVER_TEMP_BIT])
    else $error("battery over temperature flag not set");

  // [R6] low battery lands on its bit
  batt_low_bit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(charger_rtc_sync[BATT_BELOW_LOW_BIT]) |=> charger_rtc_flag[BATT_BELOW_LOW_BIT])
    else $error("battery low flag not set");

  // [R11] die hot lands on its bit
  die_hot_bit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(system_aux_sync[DIE_HOT_BIT]) |=> system_aux_flag[DIE_HOT_BIT])
    else $error("die hot flag not set");

  // [R12] watchdog lands on its bit
  watchdog_bit_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(system_aux_sync[WATCHDOG_EXPIRED_BIT]) |=> system_aux_flag[WATCHDOG_EXPIRED_BIT])
    else $error("watchdog flag not set");

  // [R13] unassigned bits stay zero
  reserved_zero_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    ((charger_rtc_flag & ~CHARGER_RTC_VALID) == '0) && ((system_aux_flag & ~SYSTEM_AUX_VALID) == '0))
    else $error("unassigned status bit is set");

  // Interrupt follows unmasked flags one cycle later.
  irq_follows_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    1'b1 |=> irq_out == $past(|(charger_rtc_flag & ~state_r.charger_rtc_mask)
                            | |(system_aux_flag & ~state_r.system_aux_mask)))
    else $error("interrupt output disagrees with unmasked flags");

  // A pin reaches its flag three edges after it rises: two synchroniser
  // stages and the flag itself. These catch a source wired to a wrong bit.
  // [R3] under temperature pin to bit
  under_temp_pin_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(battery_under_temp_src)
    |-> ##3 charger_rtc_flag[BATTERY_UNDER_TEMP_BIT])
    else $error("under temp flag not set");

  // [R4] fault pin to bit
  fault_pin_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(battery_fault_src)
    |-> ##3 charger_rtc_flag[BATTERY_FAULT_BIT])
    else $error("fault flag not set");

  // [R4] fast ready pin to bit
  fast_ready_pin_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(fast_charge_ready_src)
    |-> ##3 charger_rtc_flag[FAST_CHARGE_READY_BIT])
    else $error("fast ready flag not set");

  // [R5] second tick pin to bit
  second_pin_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(clock_second_src)
    |-> ##3 charger_rtc_flag[CLOCK_SECOND_BIT])
    else $error("second flag not set");

  // [R6] mid battery pin to bit
  batt_mid_pin_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(batt_below_mid_src)
    |-> ##3 charger_rtc_flag[BATT_BELOW_MID_BIT])
    else $error("mid battery flag not set");

  // [R7] sink pin to bit
  sink_pin_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(sink_regulation_lost_src)
    |-> ##3 system_aux_flag[SINK_REGULATION_LOST_BIT])
    else $error("sink flag not set");

  // [R8] limit pin to bit
  limit_pin_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(bus_current_limit_src)
    |-> ##3 system_aux_flag[BUS_CURRENT_LIMIT_BIT])
    else $error("limit flag not set");

  // [R9] comparator one pin to bit
  compare_one_pin_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(aux_compare_one_src)
    |-> ##3 system_aux_flag[AUX_COMPARE_ONE_BIT])
    else $error("comparator one flag not set");

  // [R10] supply pin to bit
  supply_pin_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(supply_shutdown_level_src)
    |-> ##3 system_aux_flag[SUPPLY_SHUTDOWN_LEVEL_BIT])
    else $error("supply flag not set");

  // [R11] die warm pin to bit
  die_warm_pin_a: assert property (@(posedge core_clk) disable iff (!arst_n)
    $rose(die_warm_src)
    |-> ##3 system_aux_flag[DIE_WARM_BIT])
    else $error("die warm flag not set");

endmodule
`default_nettype wire

/* File: core/level_sync.sv */
// Two-stage synchroniser for a vector of independent asynchronous levels.
`timescale 1ns/1ps
`default_nettype none
module level_sync #(
  parameter int unsigned WIDTH = 16
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output var  logic [WIDTH-1:0] sync_out
);

  typedef struct packed {
    logic [WIDTH-1:0] stage1;
    logic [WIDTH-1:0] stage2;
  } sync_state_t;

  sync_state_t state_r;
  sync_state_t state_nxt;

  // Each bit crosses on its own, so no bus coherency is implied.
  always_comb begin
    state_nxt.stage1 = async_in;
    state_nxt.stage2 = state_r.stage1;
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign sync_out = state_r.stage2;

endmodule
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for the event status block: edges, clear on read, masks, interrupt.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import event_status_pkg::*;

  typedef struct packed {
    word_t exp;
    logic  acc;
  } note_t;

  logic              core_clk = 1'b0;
  logic              arst_n = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 8'h00;
  word_t             reg_wdata = 16'h0000;
  logic              reg_wr = 1'b0;
  logic              reg_rd = 1'b0;
  word_t             reg_rdata;
  logic              irq_out;
  logic [31:0]       s = 32'h0000_0000;
  logic [31:0]       seed = 32'h4bb00aef;
  logic [31:0]       valid_all;
  note_t             notes[$];
  logic              rd_q = 1'b0;
  word_t             acc_v = 16'h0000;
  int                hits = 0;
  int                error_cnt = 0;
  int                comparisons = 0;

  assign valid_all = {SYSTEM_AUX_VALID, CHARGER_RTC_VALID};

  // ==========================================================================
  // Clock, xorshift source and shared tasks
  initial begin
    forever #12.5 core_clk = ~core_clk;
  end

  function automatic logic [31:0] xs(input logic [31:0] v);
    logic [31:0] t;
    t = v ^ (v << 13);
    t = t ^ (t >> 17);
    return t ^ (t << 5);
  endfunction

  task automatic chk(input string what, input word_t exp, input word_t got);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Bus tasks leave their strobe up so that accesses may run back to back.
  task automatic idle(input int n);
    reg_rd <= 1'b0;
    reg_wr <= 1'b0;
    repeat (n) @(posedge core_clk);
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input word_t d);
    reg_rd    <= 1'b0;
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge core_clk);
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input word_t e, input logic acc = 1'b0);
    reg_wr   <= 1'b0;
    reg_rd   <= 1'b1;
    reg_addr <= a;
    notes.push_back('{exp: e, acc: acc});
    @(posedge core_clk);
  endtask

  task automatic wrap_up;
    $display("comparisons %0d errors %0d", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  // ==========================================================================
  // Read data watcher: data stands only in the cycle after a read strobe
  always @(posedge core_clk) begin
    note_t n;
    if (rd_q) begin
      if (notes.size() == 0) begin
        chk("unexpected read", 16'h0000, 16'hffff);
      end else begin
        n = notes.pop_front();
        if (n.acc) begin
          acc_v = acc_v | reg_rdata;
          if (reg_rdata !== 16'h0000) hits++;
        end else begin
          chk("reg_rdata", n.exp, reg_rdata);
        end
      end
    end else if (arst_n) begin
      chk("reg_rdata idle", READ_IDLE, reg_rdata);
    end
    rd_q = reg_rd;
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    chk("watchdog", 16'h0000, 16'h0001);
    wrap_up();
  end

  // ==========================================================================
  // Main sequence
  initial begin
    logic [ADDR_W-1:0] a;
    word_t             w;
    repeat (6) @(posedge core_clk);
    arst_n <= 1'b1;
    idle(1);
    rd(CHARGER_RTC_EVENT_STATUS_ADDR, STATUS_RESET);
    rd(SYSTEM_AUX_EVENT_STATUS_ADDR, STATUS_RESET);
    rd(CHARGER_RTC_EVENT_MASK_ADDR, MASK_RESET);
    wr(8'h00, 16'hffff);
    wr(CHARGER_RTC_EVENT_STATUS_ADDR, 16'hffff);
    rd(8'h00, 16'h0000);
    rd(CHARGER_RTC_EVENT_STATUS_ADDR, 16'h0000);
    idle(2);
    for (int i = 0; i < 32; i++) begin
      if (valid_all[i]) begin
        a = (i < 16) ? CHARGER_RTC_EVENT_STATUS_ADDR : SYSTEM_AUX_EVENT_STATUS_ADDR;
        w = (i < 16) ? word_t'(32'h1 << i) : word_t'(32'h1 << (i - 16));
        s <= 32'h1 << i;
        idle(5);
        chk("irq_out set", 16'h0001, {15'h0, irq_out});
        rd(a, w);
        rd(a, 16'h0000);
        idle(5);
        chk("irq_out clear", 16'h0000, {15'h0, irq_out});
        rd(a, 16'h0000);
        s <= 32'h0;
        idle(3);
      end
    end
    acc_v = 16'h0000;
    hits  = 0;
    s <= 32'h1 << CLOCK_ALARM_BIT;
    for (int k = 0; k < 7; k++) begin
      rd(CHARGER_RTC_EVENT_STATUS_ADDR, 16'h0000, 1'b1);
    end
    idle(2);
    chk("edge during read", 16'h0020, acc_v);
    chk("edge read count", 16'h0001, word_t'(hits));
    s <= 32'h0;
    wr(CHARGER_RTC_EVENT_MASK_ADDR, 16'hffff);
    wr(SYSTEM_AUX_EVENT_MASK_ADDR, 16'hffff);
    rd(CHARGER_RTC_EVENT_MASK_ADDR, CHARGER_RTC_VALID);
    rd(SYSTEM_AUX_EVENT_MASK_ADDR, SYSTEM_AUX_VALID);
    s <= 32'h0001_8000;
    idle(6);
    chk("irq_out masked", 16'h0000, {15'h0, irq_out});
    wr(CHARGER_RTC_EVENT_MASK_ADDR, 16'h0000);
    idle(3);
    chk("irq_out unmasked", 16'h0001, {15'h0, irq_out});
    wr(CHARGER_RTC_EVENT_STATUS_ADDR, 16'h8000);
    idle(3);
    chk("irq_out w1c", 16'h0000, {15'h0, irq_out});
    rd(CHARGER_RTC_EVENT_STATUS_ADDR, 16'h0000);
    wr(SYSTEM_AUX_EVENT_MASK_ADDR, 16'h0000);
    wr(SYSTEM_AUX_EVENT_STATUS_ADDR, 16'h0000);
    idle(3);
    chk("irq_out second", 16'h0001, {15'h0, irq_out});
    rd(SYSTEM_AUX_EVENT_STATUS_ADDR, 16'h0001);
    idle(3);
    chk("irq_out read clear", 16'h0000, {15'h0, irq_out});
    s <= 32'h0;
    idle(3);
    for (int r = 0; r < 12; r++) begin
      seed = xs(seed);
      s <= seed;
      idle(5);
      rd(CHARGER_RTC_EVENT_STATUS_ADDR, seed[15:0] & CHARGER_RTC_VALID);
      rd(SYSTEM_AUX_EVENT_STATUS_ADDR, seed[31:16] & SYSTEM_AUX_VALID);
      rd(SYSTEM_AUX_EVENT_STATUS_ADDR, 16'h0000);
      s <= 32'h0;
      idle(4);
    end
    s <= 32'h1 << CHARGE_TIMEOUT_BIT;
    idle(5);
    s <= 32'h0;
    idle(2);
    arst_n <= 1'b0;
    idle(3);
    arst_n <= 1'b1;
    idle(1);
    rd(CHARGER_RTC_EVENT_STATUS_ADDR, STATUS_RESET);
    idle(3);
    chk("notes left", 16'h0000, word_t'(notes.size()));
    wrap_up();
  end

  event_status_top dut_u (
    .core_clk                  (core_clk),
    .arst_n                    (arst_n),
    .reg_addr                  (reg_addr),
    .reg_wdata                 (reg_wdata),
    .reg_wr                    (reg_wr),
    .reg_rd                    (reg_rd),
    .reg_rdata                 (reg_rdata),
    .irq_out                   (irq_out),
    .battery_over_temp_src     (s[BATTERY_OVER_TEMP_BIT]),
    .battery_under_temp_src    (s[BATTERY_UNDER_TEMP_BIT]),
    .battery_fault_src         (s[BATTERY_FAULT_BIT]),
    .charge_timeout_src        (s[CHARGE_TIMEOUT_BIT]),
    .charge_final_stage_src    (s[CHARGE_FINAL_STAGE_BIT]),
    .charge_begun_src          (s[CHARGE_BEGUN_BIT]),
    .fast_charge_ready_src     (s[FAST_CHARGE_READY_BIT]),
    .clock_periodic_src        (s[CLOCK_PERIODIC_BIT]),
    .clock_second_src          (s[CLOCK_SECOND_BIT]),
    .clock_alarm_src           (s[CLOCK_ALARM_BIT]),
    .batt_below_high_src       (s[BATT_BELOW_HIGH_BIT]),
    .batt_below_mid_src        (s[BATT_BELOW_MID_BIT]),
    .batt_below_low_src        (s[BATT_BELOW_LOW_BIT]),
    .sink_regulation_lost_src  (s[16+SINK_REGULATION_LOST_BIT]),
    .bus_current_limit_src     (s[16+BUS_CURRENT_LIMIT_BIT]),
    .aux_conv_done_src         (s[16+AUX_CONV_DONE_BIT]),
    .aux_compare_four_src      (s[16+AUX_COMPARE_FOUR_BIT]),
    .aux_compare_three_src     (s[16+AUX_COMPARE_THREE_BIT]),
    .aux_compare_two_src       (s[16+AUX_COMPARE_TWO_BIT]),
    .aux_compare_one_src       (s[16+AUX_COMPARE_ONE_BIT]),
    .supply_shutdown_level_src (s[16+SUPPLY_SHUTDOWN_LEVEL_BIT]),
    .die_warm_src              (s[16+DIE_WARM_BIT]),
    .die_hot_src               (s[16+DIE_HOT_BIT]),
    .watchdog_expired_src      (s[16+WATCHDOG_EXPIRED_BIT])
  );
endmodule
`default_nettype wire
